// ### rtl/obc_option_byte_decoder.sv
// option byte store access, power-up latch and configuration decode
//
// Operation
// - the option bytes have no bus address except while programming mode is active.
// - an erased store and the latch before loading read as all ones.
// - on factory-coded parts the bytes are fixed constants and writes are ignored.
// - grouping bit 1 puts port C on vector B, bit 0 puts it on vector A.
// - protect bit 1 blocks external access to program memory, 0 allows it.
// - clearing the protect bit starts an erase of the whole program memory.
// - byte 1 bit 7 at 0 enables the clock filter and at 1 disables it.
// - byte 1 bits 6:4 select the main clock source.
// - byte 1 bits 3:2 select the brownout threshold or switch it off.
// - byte 1 bit 1 at 1 resets on halt while the watchdog runs.
// - byte 1 bit 0 at 0 keeps the watchdog enabled by hardware.
//
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module obc_option_byte_decoder #(
	parameter bit ROM_CODED = 1'b0,
	parameter logic [7:0] ROM_BYTE0 = 8'hfe,
	parameter logic [7:0] ROM_BYTE1 = 8'hef
) (
	input wire logic clk,
	input wire logic sys_rst,
	// classic wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// programming mode pin from the tool
	input wire logic progModePin,
	// non-volatile store
	input wire logic [7:0] optStore0,
	input wire logic [7:0] optStore1,
	output logic optWrStrobe,
	output logic optWrIndex,
	output logic [7:0] optWrData,
	// program memory erase handshake
	output logic progEraseReq,
	input wire logic progEraseDone,
	// port interrupt requests and grouped vectors
	input wire logic portAIrq,
	input wire logic portBIrq,
	input wire logic portCIrq,
	output logic extIrqVectorA,
	output logic extIrqVectorB,
	// decoded configuration
	output logic configValid,
	output logic readoutProtect,
	output logic clockFilterEnable,
	output obc_pkg::obc_clk_src_t mainClockSourceSelect,
	output logic brownoutEnable,
	output obc_pkg::obc_brownout_t brownoutThresholdSelect,
	output logic watchdogResetOnHalt,
	output logic watchdogHwEnable
);

	function automatic obc_pkg::obc_clk_src_t decodeOsc(input logic [2:0] f);
		obc_pkg::obc_clk_src_t s;
		s = obc_pkg::OBC_SRC_EXT_CLOCK;
		casez (f)
			3'b111: s = obc_pkg::OBC_SRC_EXT_CLOCK;
			3'b110: s = obc_pkg::OBC_SRC_INT_RC;
			3'b10?: s = obc_pkg::OBC_SRC_EXT_RC;
			3'b011: s = obc_pkg::OBC_SRC_LOW_POWER_RES;
			3'b010: s = obc_pkg::OBC_SRC_MED_POWER_RES;
			3'b001: s = obc_pkg::OBC_SRC_MED_SPEED_RES;
			default: s = obc_pkg::OBC_SRC_HIGH_SPEED_RES;
		endcase
		return s;
	endfunction

	function automatic obc_pkg::obc_brownout_t decodeBo(input logic [1:0] f);
		obc_pkg::obc_brownout_t b;
		b = obc_pkg::OBC_BO_OFF;
		case (f)
			2'h3: b = obc_pkg::OBC_BO_OFF;
			2'h2: b = obc_pkg::OBC_BO_HIGH;
			2'h1: b = obc_pkg::OBC_BO_MEDIUM;
			default: b = obc_pkg::OBC_BO_LOW;
		endcase
		return b;
	endfunction

	// store view: rom parts never look at the flash
	logic [7:0] store0;
	logic [7:0] store1;
	assign store0 = ROM_CODED ? ROM_BYTE0 : optStore0;
	assign store1 = ROM_CODED ? ROM_BYTE1 : optStore1;

	// programming mode pin synchroniser
	logic progS1_r;
	logic progS2_r;
	logic progS3_r;
	logic progMode_r;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			progS1_r <= 1'b0;
			progS2_r <= 1'b0;
			progS3_r <= 1'b0;
		end else begin
			progS1_r <= progModePin;
			progS2_r <= progS1_r;
			progS3_r <= progS2_r;
		end
	end

	// change accepted only once the last two stages agree
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			progMode_r <= 1'b0;
		else if (progS2_r == progS3_r)
			progMode_r <= progS3_r;
	end

	// power-up latch, erased value until the first edge after release
	logic loaded_r;
	logic [7:0] latch0_r;
	logic [7:0] latch1_r;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			loaded_r <= 1'b0;
			latch0_r <= obc_pkg::ERASED_BYTE;
			latch1_r <= obc_pkg::ERASED_BYTE;
		end else if (!loaded_r) begin
			// a port value cannot be taken under async reset, so load here
			loaded_r <= 1'b1;
			latch0_r <= store0;
			latch1_r <= store1;
		end
	end

	// wishbone decode
	logic busReq;
	logic optHit0;
	logic optHit1;
	logic statusHit;
	logic optWrite;
	logic eraseBusy_r;
	assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// outside programming mode the option offsets behave as unmapped
	assign optHit0 = progMode_r && wb_adr_i == obc_pkg::OPT_BYTE0_OFFS;
	assign optHit1 = progMode_r && wb_adr_i == obc_pkg::OPT_BYTE1_OFFS;
	assign statusHit = wb_adr_i == obc_pkg::STATUS_OFFS;
	// writes during an erase are dropped; the tool polls status first
	assign optWrite = busReq && wb_we_i && wb_sel_i[0] && (optHit0 || optHit1)
		&& !ROM_CODED && !eraseBusy_r;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= busReq;
			if (busReq && !wb_we_i) begin
				wb_dat_o <= 32'h0;
				if (optHit0)
					wb_dat_o[7:0] <= store0;
				else if (optHit1)
					wb_dat_o[7:0] <= store1;
				else if (statusHit) begin
					wb_dat_o[obc_pkg::ST_LOADED_BIT] <= loaded_r;
					wb_dat_o[obc_pkg::ST_PROG_BIT] <= progMode_r;
					wb_dat_o[obc_pkg::ST_ERASE_BIT] <= eraseBusy_r;
					wb_dat_o[obc_pkg::ST_PROTECT_BIT] <= readoutProtect;
				end
			end
		end
	end

	// store write strobe toward the flash
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			optWrStrobe <= 1'b0;
			optWrIndex <= 1'b0;
			optWrData <= obc_pkg::ERASED_BYTE;
		end else begin
			optWrStrobe <= optWrite;
			if (optWrite) begin
				optWrIndex <= optHit1;
				optWrData <= wb_dat_i[7:0];
			end
		end
	end

	// erase on a protect bit going from one to zero
	logic protClear;
	assign protClear = optWrite && optHit0 && store0[obc_pkg::PROTECT_BIT]
		&& !wb_dat_i[obc_pkg::PROTECT_BIT];
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			eraseBusy_r <= 1'b0;
			progEraseReq <= 1'b0;
		end else if (protClear) begin
			eraseBusy_r <= 1'b1;
			progEraseReq <= 1'b1;
		end else if (progEraseDone) begin
			eraseBusy_r <= 1'b0;
			progEraseReq <= 1'b0;
		end
	end

	// decoded outputs, stable until the next reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			configValid <= 1'b0;
			readoutProtect <= 1'b1;
			clockFilterEnable <= 1'b0;
			mainClockSourceSelect <= obc_pkg::OBC_SRC_EXT_CLOCK;
			brownoutEnable <= 1'b0;
			brownoutThresholdSelect <= obc_pkg::OBC_BO_OFF;
			watchdogResetOnHalt <= 1'b1;
			watchdogHwEnable <= 1'b0;
		end else begin
			configValid <= loaded_r;
			readoutProtect <= latch0_r[obc_pkg::PROTECT_BIT];
			clockFilterEnable <= !latch1_r[obc_pkg::FILTER_OFF_BIT];
			mainClockSourceSelect <=
				decodeOsc(latch1_r[obc_pkg::OSC_MSB:obc_pkg::OSC_LSB]);
			brownoutEnable <= latch1_r[obc_pkg::BROWNOUT_MSB:obc_pkg::BROWNOUT_LSB]
				!= obc_pkg::BROWNOUT_OFF;
			brownoutThresholdSelect <=
				decodeBo(latch1_r[obc_pkg::BROWNOUT_MSB:obc_pkg::BROWNOUT_LSB]);
			watchdogResetOnHalt <= latch1_r[obc_pkg::WATCHDOG_RESET_ON_HALT_BIT];
			watchdogHwEnable <= !latch1_r[obc_pkg::WATCHDOG_SOFTWARE_ACTIVATION_BIT];
		end
	end

	// interrupt grouping, registered one cycle
	logic portCOnA;
	assign portCOnA = !latch0_r[obc_pkg::IRQ_GROUP_BIT];
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			extIrqVectorA <= 1'b0;
			extIrqVectorB <= 1'b0;
		end else begin
			extIrqVectorA <= loaded_r && (portAIrq || (portCOnA && portCIrq));
			extIrqVectorB <= loaded_r && (portBIrq || (!portCOnA && portCIrq));
		end
	end

endmodule // obc_option_byte_decoder

// ### rtl/obc_pkg.sv
// constants and types for the option byte configuration decoder
package obc_pkg;
	// bus word offsets
	localparam logic [3:0] OPT_BYTE0_OFFS = 4'h0;
	localparam logic [3:0] OPT_BYTE1_OFFS = 4'h4;
	localparam logic [3:0] STATUS_OFFS = 4'h8;

	// erased content of the store
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// option byte 0 fields
	localparam int IRQ_GROUP_BIT = 1;
	localparam int PROTECT_BIT = 0;

	// option byte 1 fields
	localparam int FILTER_OFF_BIT = 7;
	localparam int OSC_MSB = 6;
	localparam int OSC_LSB = 4;
	localparam int BROWNOUT_MSB = 3;
	localparam int BROWNOUT_LSB = 2;
	localparam int WATCHDOG_RESET_ON_HALT_BIT = 1;
	localparam int WATCHDOG_SOFTWARE_ACTIVATION_BIT = 0;

	// status register fields
	localparam int ST_LOADED_BIT = 0;
	localparam int ST_PROG_BIT = 1;
	localparam int ST_ERASE_BIT = 2;
	localparam int ST_PROTECT_BIT = 3;

	// brownout field code that switches detection off
	localparam logic [1:0] BROWNOUT_OFF = 2'h3;

	typedef enum logic [2:0] {
		OBC_SRC_EXT_CLOCK,
		OBC_SRC_INT_RC,
		OBC_SRC_EXT_RC,
		OBC_SRC_LOW_POWER_RES,
		OBC_SRC_MED_POWER_RES,
		OBC_SRC_MED_SPEED_RES,
		OBC_SRC_HIGH_SPEED_RES
	} obc_clk_src_t;

	typedef enum logic [1:0] {
		OBC_BO_OFF,
		OBC_BO_HIGH,
		OBC_BO_MEDIUM,
		OBC_BO_LOW
	} obc_brownout_t;
endpackage

// ### tb/obc_store_model.sv
// flash option store and erase responder on the programming side
`timescale 1ns/1ps
module obc_store_model (
	input wire logic clk,
	input wire logic wrStrobe,
	input wire logic wrIndex,
	input wire logic [7:0] wrData,
	input wire logic eraseReq,
	input wire logic [3:0] eraseDelay,
	output logic [7:0] store0,
	output logic [7:0] store1,
	output logic eraseDone
);
	logic [3:0] waitCnt;
	// flash keeps its content through reset, so nothing here is reset
	initial begin
		store0 = 8'hff;
		store1 = 8'hff;
	end
	always @(posedge clk) begin
		if (wrStrobe && wrIndex) begin
			store1 <= wrData;
		end
		if (wrStrobe && !wrIndex) begin
			store0 <= wrData;
		end
		waitCnt <= eraseReq ? waitCnt + 4'h1 : 4'h0;
		// one done pulse per request, after a chosen delay
		eraseDone <= eraseReq && !eraseDone && waitCnt == eraseDelay;
	end
endmodule // obc_store_model

// ### tb/obc_decoder_sva.sv
// concurrent checks on the decoder ports
`timescale 1ns/1ps
module obc_decoder_sva (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	input wire logic progModePin,
	input wire logic optWrStrobe,
	input wire logic progEraseReq,
	input wire logic progEraseDone,
	input wire logic portAIrq,
	input wire logic portBIrq,
	input wire logic portCIrq,
	input wire logic extIrqVectorA,
	input wire logic extIrqVectorB,
	input wire logic configValid,
	input wire logic readoutProtect,
	input wire logic brownoutEnable,
	input obc_pkg::obc_brownout_t brownoutThresholdSelect
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ack long");
	property p_idle;
		(!progModePin) [*6] ##0 (wb_stb_i && wb_we_i && !wb_ack_o) |=> !optWrStrobe;
	endproperty
	a_idle: assert property (p_idle) else $error("write seen");
	property p_erfall;
		progEraseReq && progEraseDone |=> !progEraseReq;
	endproperty
	a_erfall: assert property (p_erfall) else $error("erase held");
	property p_erstart;
		$rose(progEraseReq) |-> optWrStrobe;
	endproperty
	a_erstart: assert property (p_erstart) else $error("erase start");
	property p_hold;
		configValid |=> configValid && $stable(readoutProtect)
			&& $stable(brownoutThresholdSelect);
	endproperty
	a_hold: assert property (p_hold) else $error("config moved");
	property p_vec;
		configValid && !portCIrq |=> extIrqVectorA == $past(portAIrq)
			&& extIrqVectorB == $past(portBIrq);
	endproperty
	a_vec: assert property (p_vec) else $error("vector bad");
	property p_bo;
		brownoutEnable == (brownoutThresholdSelect != obc_pkg::OBC_BO_OFF);
	endproperty
	a_bo: assert property (p_bo) else $error("brownout bad");
endmodule // obc_decoder_sva
bind obc_option_byte_decoder obc_decoder_sva u_sva (.clk(clk),
	.sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .progModePin(progModePin),
	.optWrStrobe(optWrStrobe), .progEraseReq(progEraseReq),
	.progEraseDone(progEraseDone), .portAIrq(portAIrq), .portBIrq(portBIrq),
	.portCIrq(portCIrq), .extIrqVectorA(extIrqVectorA),
	.extIrqVectorB(extIrqVectorB), .configValid(configValid),
	.readoutProtect(readoutProtect), .brownoutEnable(brownoutEnable),
	.brownoutThresholdSelect(brownoutThresholdSelect));

// ### tb/option_byte_config_decoder_tb.sv
// self-checking bench for the option byte decoder
`timescale 1ns/1ps
module option_byte_config_decoder_tb;
	logic clk, sys_rst, cyc, stb, we, prog, ack, wst, wi, erq, edn;
	logic va, vb, cv, pr, fe, be, wh, hw;
	logic [3:0] adr, dly;
	logic [31:0] dat, q, datO;
	logic [2:0] irq;
	logic [7:0] b0, b1, s0, s1, wd;
	obc_pkg::obc_clk_src_t src;
	obc_pkg::obc_brownout_t bo;
	int errors = 0, tests_run = 0, cycCount = 0;
	// factory-coded twin: fixed bytes, writes must never reach the store
	logic rpr, rfe, rbe, rwh, rhw, rcv, rwst, rack, rwi, rerq, rva, rvb;
	logic [7:0] rwd;
	logic [31:0] rdat;
	logic romWrote = 1'b0;
	obc_pkg::obc_clk_src_t rsrc;
	obc_pkg::obc_brownout_t rbo;
	obc_option_byte_decoder #(.ROM_CODED(1'b1)) u_rom (.clk(clk),
		.sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(rack), .progModePin(prog), .optStore0(s0),
		.optStore1(s1), .optWrStrobe(rwst), .optWrIndex(rwi),
		.optWrData(rwd), .progEraseReq(rerq), .progEraseDone(1'b0),
		.portAIrq(irq[0]), .portBIrq(irq[1]), .portCIrq(irq[2]),
		.extIrqVectorA(rva), .extIrqVectorB(rvb), .configValid(rcv),
		.readoutProtect(rpr), .clockFilterEnable(rfe),
		.mainClockSourceSelect(rsrc), .brownoutEnable(rbe),
		.brownoutThresholdSelect(rbo), .watchdogResetOnHalt(rwh),
		.watchdogHwEnable(rhw));
	always @(posedge clk) begin
		if (rwst === 1'b1) begin
			romWrote <= 1'b1;
		end
	end
	// expected decode of a byte pair, packed as {pr, fe, src, be, bo, wh, hw, cv}
	function automatic logic [10:0] cfgExp(input logic [7:0] c0, c1);
		logic [2:0] s;
		s = c1[6:4];
		return {c0[0], ~c1[7], 3'(s > 5 ? 7 - s : s > 3 ? 2 : 6 - s),
			c1[3:2] != 2'h3, 2'h3 - c1[3:2], c1[1], ~c1[0], 1'b1};
	endfunction
	obc_option_byte_decoder u_dut (.clk(clk), .sys_rst(sys_rst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack),
		.progModePin(prog), .optStore0(s0), .optStore1(s1),
		.optWrStrobe(wst), .optWrIndex(wi), .optWrData(wd),
		.progEraseReq(erq), .progEraseDone(edn), .portAIrq(irq[0]),
		.portBIrq(irq[1]), .portCIrq(irq[2]), .extIrqVectorA(va),
		.extIrqVectorB(vb), .configValid(cv), .readoutProtect(pr),
		.clockFilterEnable(fe), .mainClockSourceSelect(src),
		.brownoutEnable(be), .brownoutThresholdSelect(bo),
		.watchdogResetOnHalt(wh), .watchdogHwEnable(hw));
	obc_store_model u_store (.clk(clk), .wrStrobe(wst), .wrIndex(wi),
		.wrData(wd), .eraseReq(erq), .eraseDelay(dly), .store0(s0),
		.store1(s1), .eraseDone(edn));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] s, e);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		{cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = datO;
		{cyc, stb} <= 2'h0;
	endtask
	task automatic reboot();
		sys_rst <= 1'b1;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	task automatic expect_cfg(input logic [7:0] c0, c1);
		chk({pr, fe, src, be, bo, wh, hw, cv},
			cfgExp(c0, c1));
		chk({rpr, rfe, rsrc, rbe, rbo, rwh, rhw, rcv},
			cfgExp(8'hfe, 8'hef));
		irq <= 3'h3;
		repeat (2) @(posedge clk);
		irq <= 3'h4;
		repeat (2) @(posedge clk);
		chk({va, vb}, {~c0[1], c0[1]});
		irq <= 3'h0;
	endtask
	task automatic results();
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// a hang ends the run as a failure
	always @(posedge clk) begin
		cycCount++;
		if (cycCount == 5000) begin
			errors++;
			results();
		end
	end
	initial begin
		{cyc, stb, we, prog, adr, dat, irq, dly} = '0;
		sys_rst = 1'b1;
		reboot();
		expect_cfg(8'hff, 8'hff);
		bus(1'b0, 4'h0, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, 4'h0, 32'h0);
		prog <= 1'b1;
		repeat (6) @(posedge clk);
		bus(1'b0, 4'h0, 32'h0);
		chk(q, 32'hff);
		bus(1'b0, 4'h8, 32'h0);
		chk(q, 32'hb);
		bus(1'b0, 4'hc, 32'h0);
		chk(q, 32'h0);
		for (int i = 0; i < 8; i++) begin
			b0 = {6'h3f, i[1], i[0]};
			b1 = {i[0], i[2:0], i[1:0], i[1], i[2]};
			dly <= 4'(i * 2);
			bus(1'b1, 4'h4, {24'h0, b1});
			bus(1'b1, 4'h0, {24'h0, b0});
			chk(erq, {31'h0, ~i[0]});
			while (erq) @(posedge clk);
			bus(1'b0, 4'h4, 32'h0);
			chk(q, {24'h0, b1});
			reboot();
			expect_cfg(b0, b1);
		end
		chk(romWrote, 1'b0);
		results();
	end
endmodule // option_byte_config_decoder_tb
